// ==== shared/ards_pkg.sv ====
/*
  Constants, register map and types of the ADC result DMA sequencer.
  Assumes byte-wide special-function registers selected by a small index.
*/
package ards_pkg;
  // ************************************************************
  // Register indices and reset value
  // ************************************************************
  localparam int unsigned REG_AW = 4;
  localparam logic [3:0] REG_CTRL = 4'h0;
  localparam logic [3:0] REG_CFG = 4'h1;
  localparam logic [3:0] REG_IWA = 4'h2;
  localparam logic [3:0] REG_IDT = 4'h3;
  localparam logic [3:0] REG_BND = 4'h4;
  localparam logic [3:0] REG_LIML = 4'h5;
  localparam logic [3:0] REG_LIMH = 4'h6;
  localparam logic [3:0] REG_DAL = 4'h7;
  localparam logic [3:0] REG_DAH = 4'h8;
  localparam logic [3:0] REG_DSL = 4'h9;
  localparam logic [3:0] REG_DSH = 4'hA;
  localparam logic [3:0] REG_CSL = 4'hB;
  localparam logic [3:0] REG_CSH = 4'hC;
  localparam logic [3:0] REG_ISW = 4'hD;
  localparam logic [7:0] REG_RESET = 8'h00;
  localparam logic [7:0] CTL_STORE = 8'h7F;
  localparam logic [7:0] CFG_STORE = 8'h8F;
  // ************************************************************
  // Bit positions
  // ************************************************************
  localparam int CTL_EN = 7;
  localparam int CTL_INT = 6;
  localparam int CTL_MD = 5;
  localparam int CTL_DE0 = 3;
  localparam int CTL_DOE = 2;
  localparam int CTL_DO1 = 1;
  localparam int CTL_DO0 = 0;
  localparam int CFG_CIE = 3;
  localparam int CFG_CI = 2;
  localparam int CFG_EOE = 1;
  localparam int CFG_EO = 0;
  localparam int INS_CONTINUOUS_BIT = 7;
  localparam int INS_DIFF = 6;
  localparam int INS_A1 = 5;
  localparam int INS_A0 = 4;
  localparam logic [6:0] INS_EOP = 7'h00;
  // ************************************************************
  // Steps and sizes
  // ************************************************************
  localparam int unsigned IB_DEPTH = 64;
  localparam logic [15:0] WP_STEP = 16'h0002;
  localparam logic [15:0] RPT_ONE = 16'h0001;
  localparam logic [15:0] RPT_ZERO = 16'h0000;
  localparam logic [5:0] IP_STEP = 6'h01;
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_FETCH = 3'b001,
    ST_LOAD = 3'b010,
    ST_EXEC = 3'b011,
    ST_DRAIN = 3'b100
  } ards_state_t;
endpackage

// ==== hw/ards_ibuf.sv ====
/*
  Instruction buffer memory: one write port, one registered read port.
  Assumes a single clock; read data lags the address by one edge.
*/
`timescale 1ns/10ps
module ards_ibuf #(
  parameter int DEPTH = 64,
  parameter int AW = 6
) (
  input wire logic clk,
  input wire logic we,
  input wire logic [AW-1:0] waddr,
  input wire logic [7:0] wdata,
  input wire logic [AW-1:0] raddr,
  output logic [7:0] rdata
);
  logic [7:0] mem [DEPTH];

  // Storage has no reset; software loads it before enabling the engine.
  always_ff @(posedge clk)
  begin
    if (we)
    begin
      mem[waddr] <= wdata;
    end
    rdata <= mem[raddr];
  end
endmodule // ards_ibuf

// ==== hw/ards_skid.sv ====
/*
  Two-entry buffer with valid and ready on both sides.
  Assumes one clock; output data and valid come straight from flip-flops.
*/
`timescale 1ns/10ps
module ards_skid #(
  parameter int W = 32
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic in_valid,
  input wire logic [W-1:0] in_data,
  output logic in_ready,
  output logic out_valid,
  output logic [W-1:0] out_data,
  input wire logic out_ready,
  output logic empty
);
  logic sp_v;
  logic [W-1:0] sp;
  logic next_hd_v;
  logic next_sp_v;
  logic [W-1:0] next_hd;
  logic [W-1:0] next_sp;
  logic push;

  assign in_ready = !sp_v;
  assign empty = !out_valid;

  // The spare slot absorbs one word while the head is stalled.
  always_comb
  begin
    push = in_valid && !sp_v;
    next_hd_v = out_valid;
    next_hd = out_data;
    next_sp_v = sp_v;
    next_sp = sp;
    if ((out_valid && out_ready) || !out_valid)
    begin
      next_hd_v = sp_v || push;
      next_hd = sp_v ? sp : in_data;
      next_sp_v = 1'b0;
    end
    else if (push)
    begin
      next_sp_v = 1'b1;
      next_sp = in_data;
    end
  end

  // Registers only.
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      out_valid <= 1'b0;
      sp_v <= 1'b0;
      out_data <= '0;
      sp <= '0;
    end
    else
    begin
      out_valid <= next_hd_v;
      sp_v <= next_sp_v;
      out_data <= next_hd;
      sp <= next_sp;
    end
  end
endmodule // ards_skid

// ==== hw/ards_top.sv ====
/*
  ADC result DMA sequencer: registers, instruction sequencer, per-ADC
  holding buffers and the path to the shared data RAM write port.
  Assumes ADC result ports hold the last result and pulse done on the same
  clock; the RAM grant is high in cycles where the core leaves RAM free.
*/
// Notes on behaviour
// - Start loads instruction pointer from boundary.
// - Repeat mode: decrement count, repeat instruction.
// - At zero reload limit, advance pointer.
// - End-of-operation returns pointer to boundary.
// - Repeat mode end: continuous continues, else stop.
// - Enabled flag raises the interrupt request.
// - Completion flag set when finished and idle.
// - Second lost conversion sets overflow error.
// - Result arriving on full buffer warns.
// - Repeat overflow flag, interrupt when enabled.
// - End-of-operation flag, interrupt when enabled.
// - One-word buffer per ADC, flushed promptly.
// - No copy into buffer until flushed.
// - Further result overwrites, sets overflow error.
// - Mode bit picks list or instruction repeat.
// - List mode: count down at each 00000000b end.
// - Write pointer loads, steps two per word.
// - Codes 00000000b/10000000b are end, no data.
`timescale 1ns/10ps
module ards_top
(
  input wire logic clk,
  input wire logic rstn,
  input wire logic [ards_pkg::REG_AW-1:0] sfr_addr,
  input wire logic sfr_we,
  input wire logic [7:0] sfr_wdata,
  output logic [7:0] sfr_rdata,
  input wire logic [15:0] first_converter_data,
  input wire logic first_converter_done,
  input wire logic [15:0] second_converter_data,
  input wire logic second_converter_done,
  input wire logic ram_grant,
  output logic ram_we,
  output logic [15:0] ram_addr,
  output logic [15:0] ram_wdata,
  output logic irq
);
  import ards_pkg::*;

  // ************************************************************
  // State
  // ************************************************************
  ards_state_t state, next_state;
  logic [7:0] ctl, next_ctl, cfg, next_cfg, cur, next_cur, rd, mem_q;
  logic [5:0] ip, next_ip, bound, next_bound, iwa, next_iwa;
  logic [15:0] rpt, next_rpt, lim, next_lim, wp, next_wp, wst, next_wst, rpt_dec;
  logic [1:0] need, next_need, bv, next_bv, pd, next_pd, done;
  logic [15:0] bd [2], next_bd [2], adc [2];
  logic [31:0] f_in_data;
  logic f_in_valid, f_in_ready, f_empty, sel, running, ctl_wr, ins_end, next_irq;
  function automatic logic is_eop(input logic [7:0] q);
    is_eop = (q[6:0] == INS_EOP);
  endfunction
  assign adc[0] = first_converter_data;
  assign adc[1] = second_converter_data;
  assign done = {second_converter_done, first_converter_done};
  assign running = (state == ST_FETCH) || (state == ST_LOAD) || (state == ST_EXEC);
  assign ctl_wr = sfr_we && (sfr_addr == REG_CTRL);
  assign ins_end = (state == ST_EXEC) && (need == 2'b00);
  assign rpt_dec = rpt - RPT_ONE;
  ards_ibuf #(.DEPTH(IB_DEPTH), .AW(6)) u_ibuf (
    .clk(clk),
    .we(sfr_we && (sfr_addr == REG_IDT)),
    .waddr(iwa),
    .wdata(sfr_wdata),
    .raddr(ip),
    .rdata(mem_q)
  );
  // Stalled grants back up here, then into the holding buffers.
  ards_skid #(.W(32)) u_skid (
    .clk(clk),
    .rstn(rstn),
    .in_valid(f_in_valid),
    .in_data(f_in_data),
    .in_ready(f_in_ready),
    .out_valid(ram_we),
    .out_data({ram_addr, ram_wdata}),
    .out_ready(ram_grant),
    .empty(f_empty)
  );
  // ************************************************************
  // Next-state logic
  // ************************************************************
  // Register writes come first so that hardware setting a flag later in
  // this process wins over a software clear in the same cycle.
  always_comb
  begin
    next_state = state;
    next_ctl = ctl;
    next_cfg = cfg;
    next_cur = cur;
    next_ip = ip;
    next_bound = bound;
    next_iwa = iwa;
    next_rpt = rpt;
    next_lim = lim;
    next_wp = wp;
    next_wst = wst;
    next_need = need;
    next_bv = bv;
    next_pd = pd;
    next_bd = bd;
    if (sfr_we)
    begin
      case (sfr_addr)
        REG_CTRL: next_ctl = sfr_wdata & CTL_STORE;
        REG_CFG: next_cfg = sfr_wdata & CFG_STORE;
        REG_IWA: next_iwa = sfr_wdata[5:0];
        REG_IDT: next_iwa = iwa + IP_STEP;
        REG_BND: next_bound = sfr_wdata[5:0];
        REG_LIML: next_lim[7:0] = sfr_wdata;
        REG_LIMH: next_lim[15:8] = sfr_wdata;
        REG_DAL: next_wst[7:0] = sfr_wdata;
        REG_DAH: next_wst[15:8] = sfr_wdata;
        default: next_iwa = iwa;
      endcase
    end
    // FIRST_CONVERTER words go first when an instruction needs both and both are buffered.
    sel = !(need[0] && bv[0]);
    f_in_valid = (state == ST_EXEC) && ((need[0] && bv[0]) || (need[1] && bv[1]));
    f_in_data = {wp, bd[sel]};
    if (f_in_valid && f_in_ready)
    begin
      next_bv[sel] = 1'b0;
      next_need[sel] = 1'b0;
      next_wp = wp + WP_STEP;
    end
    // A result waits in the ADC register while the buffer is busy.
    for (int i = 0; i < 2; i++)
    begin
      if (running)
      begin
        if (pd[i] && !next_bv[i])
        begin
          next_bd[i] = adc[i];
          next_bv[i] = 1'b1;
          next_pd[i] = 1'b0;
        end
        if (done[i])
        begin
          if (!next_bv[i])
          begin
            next_bd[i] = adc[i];
            next_bv[i] = 1'b1;
          end
          else
          begin
            next_ctl[CTL_DO0 + i] = 1'b1;
            if (next_pd[i])
            begin
              next_ctl[CTL_DE0 + i] = 1'b1;
            end
            next_pd[i] = 1'b1;
          end
        end
      end
    end
    case (state)
      ST_FETCH: next_state = ST_LOAD;
      ST_LOAD:
      begin
        next_cur = mem_q;
        next_need = {mem_q[INS_A1], mem_q[INS_A0] | mem_q[INS_DIFF]};
        next_state = ST_EXEC;
      end
      ST_EXEC:
      begin
        if (ins_end)
        begin
          next_state = ST_FETCH;
          if (is_eop(cur))
          begin
            next_cfg[CFG_EO] = 1'b1;
            next_ip = bound;
            if (!cur[INS_CONTINUOUS_BIT] && ctl[CTL_MD])
            begin
              next_state = ST_DRAIN;
            end
            else if (!cur[INS_CONTINUOUS_BIT])
            begin
              next_rpt = rpt_dec;
              if (rpt_dec == RPT_ZERO)
              begin
                next_cfg[CFG_CI] = 1'b1;
                next_state = ST_DRAIN;
              end
            end
          end
          else if (ctl[CTL_MD])
          begin
            next_rpt = rpt_dec;
            if (rpt_dec == RPT_ZERO)
            begin
              next_rpt = lim;
              next_ip = ip + IP_STEP;
              next_cfg[CFG_CI] = 1'b1;
            end
          end
          else
          begin
            next_ip = ip + IP_STEP;
          end
        end
      end
      ST_DRAIN:
      begin
        if (f_empty)
        begin
          next_ctl[CTL_INT] = 1'b1;
          next_state = ST_IDLE;
        end
      end
      default: next_state = ST_IDLE;
    endcase
    // Enable writes override the sequencer: start from the top or halt.
    if (ctl_wr && sfr_wdata[CTL_EN] && (state == ST_IDLE))
    begin
      next_state = ST_FETCH;
      next_ip = bound;
      next_wp = wst;
      next_rpt = lim;
      next_need = 2'b00;
      next_bv = 2'b00;
      next_pd = 2'b00;
    end
    else if (ctl_wr && !sfr_wdata[CTL_EN])
    begin
      next_state = ST_IDLE;
      next_need = 2'b00;
      next_bv = 2'b00;
      next_pd = 2'b00;
    end
    next_irq = ctl[CTL_INT] | ctl[CTL_DE0 + 1] | ctl[CTL_DE0] |
      (ctl[CTL_DOE] & (ctl[CTL_DO1] | ctl[CTL_DO0])) |
      (cfg[CFG_CIE] & cfg[CFG_CI]) | (cfg[CFG_EOE] & cfg[CFG_EO]);
    case (sfr_addr)
      REG_CTRL: rd = ctl | {running || (state == ST_DRAIN), 7'h00};
      REG_CFG: rd = cfg;
      REG_IWA: rd = {2'b00, iwa};
      REG_BND: rd = {2'b00, bound};
      REG_LIML: rd = lim[7:0];
      REG_LIMH: rd = lim[15:8];
      REG_DAL: rd = wst[7:0];
      REG_DAH: rd = wst[15:8];
      REG_DSL: rd = wp[7:0];
      REG_DSH: rd = wp[15:8];
      REG_CSL: rd = rpt[7:0];
      REG_CSH: rd = rpt[15:8];
      REG_ISW: rd = {2'b00, ip};
      default: rd = REG_RESET;
    endcase
  end
  // ************************************************************
  // Registers
  // ************************************************************
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      state <= ST_IDLE;
      ctl <= REG_RESET;
      cfg <= REG_RESET;
      cur <= REG_RESET;
      sfr_rdata <= REG_RESET;
      irq <= 1'b0;
      ip <= '0;
      bound <= '0;
      iwa <= '0;
      rpt <= '0;
      lim <= '0;
      wp <= '0;
      wst <= '0;
      need <= '0;
      bv <= '0;
      pd <= '0;
      bd <= '{default: '0};
    end
    else
    begin
      state <= next_state;
      ctl <= next_ctl;
      cfg <= next_cfg;
      cur <= next_cur;
      sfr_rdata <= rd;
      irq <= next_irq;
      ip <= next_ip;
      bound <= next_bound;
      iwa <= next_iwa;
      rpt <= next_rpt;
      lim <= next_lim;
      wp <= next_wp;
      wst <= next_wst;
      need <= next_need;
      bv <= next_bv;
      pd <= next_pd;
      bd <= next_bd;
    end
  end
  // ************************************************************
  // Assertions
  // ************************************************************
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);

  start_load_a: assert property ((state == ST_IDLE) && ctl_wr && sfr_wdata[CTL_EN] |=>
    (state == ST_FETCH) && (ip == $past(bound)) && (wp == $past(wst)))
    else $error("start did not load pointers");
  rpt_again_a: assert property (ins_end && !is_eop(cur) && ctl[CTL_MD] && !ctl_wr &&
    (rpt > RPT_ONE) |=> (rpt == $past(rpt_dec)) && (ip == $past(ip)))
    else $error("repeat count did not step");
  rpt_reload_a: assert property (ins_end && !is_eop(cur) && ctl[CTL_MD] && !ctl_wr &&
    (rpt == RPT_ONE) |=> (rpt == $past(lim)) && cfg[CFG_CI] && (ip == $past(ip) + IP_STEP))
    else $error("repeat reload missed");
  eop_ptr_a: assert property (ins_end && is_eop(cur) |=>
    (ip == $past(bound)) && cfg[CFG_EO])
    else $error("end of operation handling wrong");
  eop_stop_a: assert property (ins_end && is_eop(cur) && ctl[CTL_MD] && !cur[INS_CONTINUOUS_BIT] &&
    !ctl_wr |=> (state == ST_DRAIN))
    else $error("mode one end did not stop");
  warn_set_a: assert property (running && first_converter_done && bv[0] &&
    !(f_in_valid && f_in_ready && !sel) && !ctl_wr |=> ctl[CTL_DO0])
    else $error("overflow warning missed");
  err_set_a: assert property (running && first_converter_done && bv[0] && pd[0] &&
    !(f_in_valid && f_in_ready && !sel) && !ctl_wr |=> ctl[CTL_DE0])
    else $error("overflow error missed");
  hold_buf_a: assert property (bv[0] && !(f_in_valid && f_in_ready && !sel) |=>
    (bd[0] == $past(bd[0])))
    else $error("full buffer overwritten");
  irq_flag_a: assert property (ctl[CTL_INT] |=> irq)
    else $error("interrupt not raised");
endmodule // ards_top

// ==== dv/ards_far_model.sv ====
/*
  Far-side model: two converters with held result registers and the shared RAM port.
  Assumes the bench pulses the conversion requests and picks the grant style.
*/
`timescale 1ns/10ps
module ards_far_model (
  input wire logic clk,
  input wire logic rstn,
  input wire logic go0,
  input wire logic go1,
  input wire logic [1:0] grant_mode,
  output logic [15:0] first_converter_data,
  output logic first_converter_done,
  output logic [15:0] second_converter_data,
  output logic second_converter_done,
  output logic ram_grant,
  input wire logic ram_we,
  input wire logic [15:0] ram_addr,
  input wire logic [15:0] ram_wdata
);
  logic [15:0] log_addr [0:63];
  logic [15:0] log_data [0:63];
  int n_wr = 0;
  logic tick;
  // ************************************************************
  // Converters
  // ************************************************************
  // A new result overwrites the held register even if the last one was never taken.
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      first_converter_data <= 16'hA000;
      second_converter_data <= 16'hB000;
      first_converter_done <= 1'b0;
      second_converter_done <= 1'b0;
      tick <= 1'b0;
    end
    else
    begin
      first_converter_done <= go0;
      second_converter_done <= go1;
      first_converter_data <= go0 ? first_converter_data + 16'h0001 : first_converter_data;
      second_converter_data <= go1 ? second_converter_data + 16'h0001 : second_converter_data;
      tick <= ~tick;
    end
  end
  // ************************************************************
  // RAM port
  // ************************************************************
  // Mode 0 leaves RAM free, 1 frees it every other cycle, 2 lets the core hold it.
  assign ram_grant = (grant_mode == 2'h0) || ((grant_mode == 2'h1) && tick);
  // Every accepted write is logged so the bench can compare order and content.
  always @(posedge clk)
  begin
    if (ram_we && ram_grant)
    begin
      log_addr[n_wr % 64] <= ram_addr;
      log_data[n_wr % 64] <= ram_wdata;
      n_wr <= n_wr + 1;
    end
  end
endmodule // ards_far_model

// ==== dv/ards_top_tb.sv ====
/*
  Self-checking bench of the sequencer: register tasks, three programs, overflow case.
  Assumes the far-side model logs RAM writes and raises conversions on request.
*/
`timescale 1ns/10ps
module ards_top_tb;
  import ards_pkg::*;
  logic clk, rstn, sfr_we, first_converter_done, second_converter_done, ram_grant, ram_we, irq, go0, go1;
  logic [3:0] sfr_addr;
  logic [7:0] sfr_wdata, sfr_rdata;
  logic [15:0] first_converter_data, second_converter_data, ram_addr, ram_wdata;
  logic [1:0] grant_mode;
  int n_mismatch = 0;
  int checked = 0;
  int base;
  ards_top u_ards_top (.clk(clk), .rstn(rstn), .sfr_addr(sfr_addr), .sfr_we(sfr_we),
    .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata), .first_converter_data(first_converter_data),
    .first_converter_done(first_converter_done), .second_converter_data(second_converter_data), .second_converter_done(second_converter_done),
    .ram_grant(ram_grant), .ram_we(ram_we), .ram_addr(ram_addr), .ram_wdata(ram_wdata),
    .irq(irq));
  ards_far_model u_ards_far_model (.clk(clk), .rstn(rstn), .go0(go0), .go1(go1),
    .grant_mode(grant_mode), .first_converter_data(first_converter_data), .first_converter_done(first_converter_done),
    .second_converter_data(second_converter_data), .second_converter_done(second_converter_done), .ram_grant(ram_grant),
    .ram_we(ram_we), .ram_addr(ram_addr), .ram_wdata(ram_wdata));
  // Free-running 50 MHz clock.
  initial
  begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  // ************************************************************
  // Tasks
  // ************************************************************
  // Prints the counts and the verdict, then ends the run.
  task automatic print_verdict();
    $display("checked %0d mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  // One write per call; the idle edge after it keeps strobes from merging.
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    sfr_addr <= a;
    sfr_wdata <= d;
    sfr_we <= 1'b1;
    @(posedge clk);
    sfr_we <= 1'b0;
  endtask
  // Read data is registered, so it is taken two edges after the address lands.
  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge clk);
    sfr_addr <= a;
    repeat (2) @(posedge clk);
    #1 d = sfr_rdata;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_reg(input logic [3:0] a, input logic [7:0] e);
    logic [7:0] d;
    rd(a, d);
    chk({8'h00, d}, {8'h00, e});
  endtask
  task automatic chk_wr(input int i, input logic [15:0] a, input logic [15:0] d);
    chk(u_ards_far_model.log_addr[i % 64], a);
    chk(u_ards_far_model.log_data[i % 64], d);
  endtask
  // Loads three instruction words from a given buffer location.
  task automatic load(input logic [7:0] at, input logic [7:0] c0, c1, c2);
    wr(REG_IWA, at);
    wr(REG_IDT, c0);
    wr(REG_IDT, c1);
    wr(REG_IDT, c2);
  endtask
  // Boundary, repeat limit and a data start address of 0x1000.
  task automatic setup(input logic [7:0] bnd, input logic [7:0] lim);
    wr(REG_BND, bnd);
    wr(REG_LIML, lim);
    wr(REG_LIMH, 8'h00);
    wr(REG_DAL, 8'h00);
    wr(REG_DAH, 8'h10);
    base = u_ards_far_model.n_wr;
  endtask
  // Spaced conversions give the engine time to fetch between results.
  task automatic fire(input logic b0, input logic b1);
    @(posedge clk);
    go0 <= b0;
    go1 <= b1;
    @(posedge clk);
    go0 <= 1'b0;
    go1 <= 1'b0;
    repeat (10) @(posedge clk);
  endtask
  // Polls the enable bit; a run that never ends counts as a mismatch.
  task automatic wait_idle();
    logic [7:0] d;
    d = 8'h80;
    for (int i = 0; i < 100 && d[7] !== 1'b0; i++)
      rd(REG_CTRL, d);
    if (d[7] !== 1'b0)
    begin
      n_mismatch++;
      $display("mismatch at %0t: engine never went idle", $time);
      print_verdict();
    end
  endtask
  // ************************************************************
  // Tests
  // ************************************************************
  initial
  begin
    rstn = 1'b0;
    sfr_addr = 4'h0;
    sfr_we = 1'b0;
    sfr_wdata = 8'h00;
    go0 = 1'b0;
    go1 = 1'b0;
    grant_mode = 2'h0;
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
    chk_reg(REG_CTRL, 8'h00);
    chk_reg(REG_CFG, 8'h00);
    chk_reg(4'hE, 8'h00);
    $display("test reset finished");
    // Whole-list mode, two passes over FIRST_CONVERTER then FIRST_CONVERTER and SECOND_CONVERTER.
    load(8'h04, 8'h10, 8'h30, 8'h00);
    setup(8'h04, 8'h02);
    chk_reg(REG_BND, 8'h04);
    chk_reg(REG_DAH, 8'h10);
    wr(REG_CFG, 8'h02);
    wr(REG_CTRL, 8'h80);
    chk_reg(REG_CTRL, 8'h80);
    repeat (2)
    begin
      fire(1'b1, 1'b0);
      fire(1'b1, 1'b1);
    end
    wait_idle();
    for (int p = 0; p < 2; p++)
    begin
      chk_wr(base + 3 * p, 16'(16'h1000 + 6 * p), 16'(16'hA001 + 2 * p));
      chk_wr(base + 3 * p + 1, 16'(16'h1002 + 6 * p), 16'(16'hA002 + 2 * p));
      chk_wr(base + 3 * p + 2, 16'(16'h1004 + 6 * p), 16'(16'hB001 + p));
    end
    chk_reg(REG_CTRL, 8'h40);
    chk_reg(REG_CFG, 8'h07);
    chk({15'h0000, irq}, 16'h0001);
    chk_reg(REG_DSL, 8'h0C);
    chk_reg(REG_ISW, 8'h04);
    wr(REG_DSL, 8'hFF);
    chk_reg(REG_DSL, 8'h0C);
    wr(REG_CTRL, 8'h00);
    wr(REG_CFG, 8'h00);
    chk_reg(REG_CTRL, 8'h00);
    chk({15'h0000, irq}, 16'h0000);
    $display("test list mode finished");
    // Per-instruction mode with a slow RAM port.
    load(8'h00, 8'h20, 8'h40, 8'h00);
    setup(8'h00, 8'h02);
    wr(REG_CFG, 8'h08);
    grant_mode <= 2'h1;
    wr(REG_CTRL, 8'hA0);
    fire(1'b0, 1'b1);
    fire(1'b0, 1'b1);
    fire(1'b1, 1'b0);
    fire(1'b1, 1'b0);
    wait_idle();
    for (int k = 0; k < 2; k++)
    begin
      chk_wr(base + k, 16'(16'h1000 + 2 * k), 16'(16'hB003 + k));
      chk_wr(base + 2 + k, 16'(16'h1004 + 2 * k), 16'(16'hA005 + k));
    end
    chk_reg(REG_CTRL, 8'h60);
    chk_reg(REG_CFG, 8'h0D);
    chk_reg(REG_CSL, 8'h02);
    chk({15'h0000, irq}, 16'h0001);
    $display("test repeat mode finished");
    // Continuous program while the core holds RAM: warning, then error.
    wr(REG_CTRL, 8'h00);
    wr(REG_CFG, 8'h00);
    load(8'h00, 8'h10, 8'h80, 8'h00);
    setup(8'h00, 8'h01);
    grant_mode <= 2'h2;
    wr(REG_CTRL, 8'hA4);
    repeat (8) fire(1'b1, 1'b0);
    chk_reg(REG_CTRL, 8'hAD);
    chk({15'h0000, irq}, 16'h0001);
    grant_mode <= 2'h0;
    repeat (10) @(posedge clk);
    chk_wr(base, 16'h1000, 16'hA007);
    wr(REG_CTRL, 8'h00);
    wait_idle();
    $display("test overflow finished");
    print_verdict();
  end
endmodule // ards_top_tb
